// [src/host_port_params.svh]
// timing and counter-width constants for the host port status block
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define REF_CLK_HZ        40000000
`define ONE_SEC_CYCLES    (`REF_CLK_HZ)
`define SEC_CNT_W         26
`define MARKER_HIGH_CYC   2
`endif

// [src/host_port_pkg.sv]
// types shared by the host port status block
package host_port_pkg;
  typedef struct packed {
    logic cs_n;
    logic addr_strobe_n;
    logic data_strobe_n;
    logic rd_wr;
  } bus_ctl_t;

  typedef struct packed {
    logic sync_bus_select;
    logic bus_style_select;
    logic marker_is_output;
  } port_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } od_pin_t;
endpackage

// [src/sync2.sv]
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// [src/host_port_status_signals.sv]
// one-second marker, interrupt request and transfer acknowledge of the host port
`timescale 1ns/10ps
`include "host_port_params.svh"
module host_port_status_signals (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_b_i,
  input  wire host_port_pkg::port_cfg_t cfg_i,
  input  wire host_port_pkg::bus_ctl_t  bus_i,
  input  wire logic                   one_second_marker_i,
  input  wire logic [7:0]             irq_pending_i,
  output logic                        one_second_marker_o,
  output logic                        one_second_marker_oe_o,
  output logic                        irq_request_n_o,
  output logic                        irq_request_n_oe_o,
  output logic                        transfer_ack_n_o,
  output logic                        transfer_ack_n_oe_o,
  output logic                        second_tick_o,
  output logic                        read_cycle_o,
  output logic                        write_cycle_o
);
  import host_port_pkg::*;

  localparam int SYN_W = 8;

  logic                  rst_meta_r;
  logic                  rst_sync_b;
  logic [SYN_W-1:0]      pins_raw;
  logic [SYN_W-1:0]      pins_s;
  bus_ctl_t              bus_s;
  port_cfg_t             cfg_s;
  logic                  marker_s;
  logic                  marker_prev_r;
  logic                  marker_rise;
  logic [`SEC_CNT_W-1:0] sec_cnt_r;
  logic                  sec_wrap;
  logic                  ack_mode;
  logic                  out_prev_r;
  logic                  out_rise;
  logic                  interval_start;
  logic [1:0]            mk_high_cnt_r;

  // reset released through two flops
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  assign pins_raw = {bus_i, cfg_i, one_second_marker_i};

  // bus, configuration and marker pins are asynchronous to the reference clock; irq_pending_i is not synchronised
  sync2 #(
    .W(SYN_W)
  ) u_pin_sync (
    .clk_i  (ref_clk_i),
    .rst_b_i(rst_sync_b),
    .d_i    (pins_raw),
    .q_o    (pins_s)
  );

  assign bus_s    = pins_s[7:4];
  assign cfg_s    = pins_s[3:1];
  assign marker_s = pins_s[0];

  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      marker_prev_r <= 1'b0;
      out_prev_r    <= 1'b0;
    end else begin
      marker_prev_r <= marker_s;
      out_prev_r    <= cfg_s.marker_is_output;
    end
  end

  assign marker_rise = marker_s & ~marker_prev_r & ~cfg_s.marker_is_output;
  assign sec_wrap    = (sec_cnt_r == `SEC_CNT_W'(`ONE_SEC_CYCLES - 1));
  // becoming the marker source opens an interval at once, not up to a second later
  assign out_rise       = cfg_s.marker_is_output & ~out_prev_r;
  assign interval_start = out_rise | (sec_wrap & cfg_s.marker_is_output);

  // one-second timer; an input edge restarts the interval
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sec_cnt_r <= '0;
    end else if (marker_rise) begin
      sec_cnt_r <= '0;
    end else if (sec_wrap | out_rise) begin
      sec_cnt_r <= '0;
    end else begin
      sec_cnt_r <= sec_cnt_r + 1'b1;
    end
  end

  // interval start pulse for status reporting
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      second_tick_o <= 1'b0;
    end else begin
      second_tick_o <= marker_rise | interval_start;
    end
  end

  // marker high for a short pulse from the interval start
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      one_second_marker_o    <= 1'b0;
      one_second_marker_oe_o <= 1'b0;
    end else begin
      one_second_marker_oe_o <= cfg_s.marker_is_output;
      one_second_marker_o    <= cfg_s.marker_is_output & (interval_start |
                                (sec_cnt_r < `SEC_CNT_W'(`MARKER_HIGH_CYC - 1)));
    end
  end

  // open drain: drive low only while requests are pending
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_request_n_o    <= 1'b1;
      irq_request_n_oe_o <= 1'b0;
    end else begin
      irq_request_n_o    <= 1'b0;
      irq_request_n_oe_o <= |irq_pending_i;
    end
  end

  // acknowledge only with sync bus and data-strobe style
  assign ack_mode = cfg_s.sync_bus_select & ~cfg_s.bus_style_select;

  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      transfer_ack_n_o    <= 1'b1;
      transfer_ack_n_oe_o <= 1'b0;
    end else begin
      transfer_ack_n_o    <= 1'b0;
      transfer_ack_n_oe_o <= ack_mode & ~bus_s.addr_strobe_n & ~bus_s.cs_n;
    end
  end

  // cycle qualification sampled on each clock edge; rd_wr high means read
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      read_cycle_o  <= 1'b0;
      write_cycle_o <= 1'b0;
    end else begin
      read_cycle_o  <= ack_mode & ~bus_s.cs_n & ~bus_s.addr_strobe_n
                       & ~bus_s.data_strobe_n & bus_s.rd_wr;
      write_cycle_o <= ack_mode & ~bus_s.cs_n & ~bus_s.addr_strobe_n
                       & ~bus_s.data_strobe_n & ~bus_s.rd_wr;
    end
  end

  // consecutive high cycles of the marker; only feeds the width check
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mk_high_cnt_r <= 2'h0;
    end else if (!one_second_marker_o) begin
      mk_high_cnt_r <= 2'h0;
    end else if (mk_high_cnt_r != 2'h3) begin
      mk_high_cnt_r <= mk_high_cnt_r + 2'h1;
    end
  end

  chk_ack_follows_strobes: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    ##1 transfer_ack_n_oe_o == $past(ack_mode & ~bus_s.addr_strobe_n & ~bus_s.cs_n))
    else $error("acknowledge does not follow strobes");
  chk_ack_mode_only: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    !ack_mode |=> !transfer_ack_n_oe_o)
    else $error("acknowledge outside sync strobe mode");
  chk_ack_low_level: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    transfer_ack_n_oe_o |-> !transfer_ack_n_o)
    else $error("acknowledge driven high");
  chk_irq_pending_low: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    (|irq_pending_i) |=> (irq_request_n_oe_o && !irq_request_n_o))
    else $error("interrupt not pulled low");
  chk_irq_release: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    (irq_pending_i == 8'h00) |=> !irq_request_n_oe_o)
    else $error("interrupt not released");
  chk_irq_low_level: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    irq_request_n_oe_o |-> !irq_request_n_o)
    else $error("interrupt driven high");
  chk_marker_align: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    marker_rise |=> (sec_cnt_r == '0) && second_tick_o)
    else $error("timer not realigned");
  chk_marker_input_oe: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    !cfg_s.marker_is_output |=> !one_second_marker_oe_o)
    else $error("marker driven while an input");
  chk_marker_out_edge: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    interval_start |=> $rose(one_second_marker_o))
    else $error("marker edge missing");
  chk_marker_width: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    mk_high_cnt_r <= 2'(`MARKER_HIGH_CYC))
    else $error("marker pulse too long");
  chk_read_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    read_cycle_o |-> $past(~bus_s.cs_n & bus_s.rd_wr))
    else $error("read cycle without select");
  chk_write_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    write_cycle_o |-> $past(ack_mode & ~bus_s.cs_n & ~bus_s.rd_wr))
    else $error("write cycle without select");
  chk_cycle_exclusive: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    !(read_cycle_o && write_cycle_o))
    else $error("read and write at once");
endmodule

// [testbench/host_cpu_model.sv]
// host processor model driving the parallel port strobes
`timescale 1ns/10ps
module host_cpu_model (
  input  wire logic               clk_i,
  output host_port_pkg::bus_ctl_t bus_o
);
  import host_port_pkg::*;
  initial bus_o = '1;
  // strobes go low together and stay until stop, so an edge always sees both
  task automatic start(input logic rd);
    @(negedge clk_i);
    bus_o = '{cs_n: 1'b0, addr_strobe_n: 1'b0, data_strobe_n: 1'b0, rd_wr: rd};
  endtask
  // strobes pulled up on release; direction line shows the inverse, not a held value
  task automatic stop();
    @(negedge clk_i);
    bus_o = '{cs_n: 1'b1, addr_strobe_n: 1'b1, data_strobe_n: 1'b1, rd_wr: ~bus_o.rd_wr};
  endtask
endmodule

// [testbench/host_port_status_signals_test.sv]
// self-checking bench for the host port status block
`timescale 1ns/10ps
module host_port_status_signals_test;
  import host_port_pkg::*;
  logic      ref_clk_i, rst_b_i, mk_i, mk_o, mk_oe, irq_o, irq_oe, ack_o, ack_oe, tick, rd_c, wr_c;
  port_cfg_t cfg;
  bus_ctl_t  bus;
  logic [7:0] pend;
  int        fails, tests_run;
  host_cpu_model m (.clk_i(ref_clk_i), .bus_o(bus));
  host_port_status_signals i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg),
    .bus_i(bus), .one_second_marker_i(mk_i), .irq_pending_i(pend),
    .one_second_marker_o(mk_o), .one_second_marker_oe_o(mk_oe), .irq_request_n_o(irq_o),
    .irq_request_n_oe_o(irq_oe), .transfer_ack_n_o(ack_o), .transfer_ack_n_oe_o(ack_oe),
    .second_tick_o(tick), .read_cycle_o(rd_c), .write_cycle_o(wr_c));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic test_irq();
    for (int i = 0; i < 8; i++) begin
      pend = 8'h01 << i;
      cyc(2);
      check(irq_oe, 1'b1);
      check(irq_o, 1'b0);
      pend = 8'h00;
      cyc(2);
      check(irq_oe, 1'b0);
    end
    pend = 8'h81;
    cyc(2);
    pend = 8'h01;
    cyc(2);
    check(irq_oe, 1'b1);
    pend = 8'h00;
    cyc(2);
    check(irq_oe, 1'b0);
    $display("irq test done");
  endtask
  task automatic test_ack();
    cfg = 3'b100;
    cyc(6);
    for (int rd = 0; rd < 2; rd++) begin
      m.start(rd[0]);
      cyc(4);
      check(ack_oe, 1'b1);
      check(ack_o, 1'b0);
      check({rd_c, wr_c}, {rd[0], ~rd[0]});
      m.stop();
      cyc(4);
      check(ack_oe, 1'b0);
      check({rd_c, wr_c}, 2'b00);
    end
    $display("ack test done");
  endtask
  task automatic test_refused();
    port_cfg_t modes [3] = '{3'b110, 3'b000, 3'b010};
    foreach (modes[k]) begin
      cfg = modes[k];
      cyc(6);
      m.start(1'b1);
      cyc(5);
      check({ack_oe, rd_c}, 2'b00);
      m.stop();
    end
    $display("refused mode test done");
  endtask
  task automatic test_marker();
    int seen;
    seen = 0;
    cfg = 3'b000;
    mk_i = 1'b0;
    cyc(8);
    check(mk_oe, 1'b0);
    mk_i = 1'b1;
    for (int c = 0; c < 8; c++) begin
      cyc(1);
      if (tick === 1'b1) seen++;
    end
    check(seen[7:0], 8'h01);
    mk_i = 1'b0;
    cyc(4);
    mk_i = 1'b1;
    cyc(3);
    check(tick, 1'b1);
    cyc(1);
    check(tick, 1'b0);
    cfg = 3'b001;
    cyc(3);
    check({mk_oe, mk_o, tick}, 3'b111);
    cyc(1);
    check({mk_o, tick}, 2'b10);
    cyc(1);
    check(mk_o, 1'b0);
    seen = 0;
    for (int c = 0; c < 100; c++) begin
      cyc(1);
      if (mk_o !== 1'b0 || tick !== 1'b0 || mk_oe !== 1'b1) seen++;
    end
    check(seen[7:0], 8'h00);
    $display("marker test done");
  endtask
  initial begin
    fails = 0;
    tests_run = 0;
    cfg = 3'b000;
    mk_i = 1'b0;
    pend = 8'h00;
    rst_b_i = 1'b0;
    cyc(4);
    rst_b_i = 1'b1;
    cyc(8);
    test_irq();
    test_ack();
    test_refused();
    test_marker();
    print_verdict();
  end
  // whole run is a few hundred cycles; this margin only catches a hang
  initial begin
    #(5000 * 25);
    fails++;
    print_verdict();
  end
endmodule
